// ### rtl/i2csp_core.sv
/*
 * i2c slave port core: start/stop detect, 7/10-bit address match,
 * automatic ack, buffer-full/overflow, clock stretching, transmit.
 * assumes external pull-ups and an external master; firmware drives
 * the plain control ports and pulses the strobes for one cycle.
 */
`timescale 1ns/10ps
// Operation
// - master mode start bit makes start, self-clears
// - slave stretch enable stretches receive only
// - busy port refuses ctrl sets; busy master refuses start set, buffer writes
// - works only when enabled; mode field selects
// - pins open-drain only when direction selects input
// - interrupt on match; optionally start/stop
// - auto ack and buffer load on match/data
// - full or overflow: no ack, no load; interrupt on data bytes only
// - buffer read clears full; overflow cleared by firmware
// - wait start, shift eight bits on rise
// - compare upper seven bits on eighth fall
// - match: load, full, ack, flag on ninth
// - ten-bit header 11110 a9 a8 write
// - ten-bit write header and low byte set update flag, hold clock
// - repeated start read header sets flag, full, rw; no update flag
// - write match clears rw, loads, acks
// - interrupt flag for every data byte
// - stretch enable holds clock after received data
// - read match sets rw, acks, always holds clock
// - buffer write loads shift register; release clock
// - transmit bits change on falling scl
// - master ack latched on ninth rise; nack resets
// - cleared release bit holds clock low
// - mode codes 0110 0111 1110 1111
// - update flag shows address rewrite needed
module i2csp_core (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic port_enable_bit,
	input wire logic [3:0] mode_select_field,
	input wire logic [1:0] pin_direction_control,
	input wire logic stretch_or_start_enable_set,
	input wire logic stretch_or_start_enable_clr,
	input wire logic [3:0] master_ctrl_set,
	input wire logic [7:0] own_address_wdata,
	input wire logic own_address_wr,
	input wire logic [7:0] data_buffer_wdata,
	input wire logic data_buffer_wr,
	input wire logic data_buffer_rd,
	input wire logic clock_release_set,
	input wire logic clock_release_clr,
	input wire logic overflow_clr,
	input wire logic interrupt_clr,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic scl_oe_n,
	output logic sda_oe_n,
	output logic scl_out,
	output logic sda_out,
	output logic [7:0] data_buffer,
	output logic [7:0] own_address_register,
	output logic [5:0] status_register,
	output logic receive_overflow_flag,
	output logic port_interrupt_flag,
	output logic clock_release_bit,
	output logic stretch_or_start_enable,
	output logic [3:0] master_ctrl
);
	import i2csp_pkg::*;

	logic scl_s, scl_rise, scl_fall; // synchronised clock and its edges
	logic sda_s, sda_rise, sda_fall; // synchronised data and its edges
	i2csp_state_type state; // byte phase
	logic [7:0] shift_register; // serial shifter
	logic [3:0] bit_cnt; // rising edges seen in this byte
	logic ack_drive; // pull sda low for ack
	logic tx_bit_low; // pull sda low for a zero data bit
	logic accept; // byte accepted (acked) this frame
	logic ten_hi_seen; // header of a ten-bit address accepted
	logic [7:0] start_cnt; // start generator timer
	logic in_frame; // between start and stop
	logic enabled, slave_mode, sp_irq, ten_mode, master_mode, busy;
	logic start_det, stop_det, byte_end, ninth_fall;
	logic addr_match7, hdr_match, low_match, is_addr_byte;
	logic buf_free;

	// pin synchronisers for the bus lines
	i2csp_sync u_scl_sync (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.pin_in(scl_in),
		.level(scl_s),
		.rise(scl_rise),
		.fall(scl_fall)
	);
	i2csp_sync u_sda_sync (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.pin_in(sda_in),
		.level(sda_s),
		.rise(sda_rise),
		.fall(sda_fall)
	);

	// mode decode; unlisted codes leave the port passive
	assign enabled = port_enable_bit;
	assign slave_mode = enabled && (mode_select_field == MODE_SLV7 ||
		mode_select_field == MODE_SLV10 || mode_select_field == MODE_SLV7_SP ||
		mode_select_field == MODE_SLV10_SP);
	assign ten_mode = mode_select_field[0]; // odd slave codes are ten-bit
	assign sp_irq = mode_select_field[3]; // start/stop interrupt variants
	assign master_mode = enabled && (mode_select_field == MODE_MASTER ||
		mode_select_field == MODE_FW_MASTER);
	// busy while a frame runs or a master sequence is pending
	assign busy = in_frame || (master_ctrl != 4'h0) || (start_cnt != 8'h00);

	// start and stop are sda edges while scl is high
	assign start_det = sda_fall && scl_s;
	assign stop_det = sda_rise && scl_s;
	assign byte_end = scl_fall && bit_cnt == BIT_LAST_DATA; // eighth fall
	assign ninth_fall = scl_fall && bit_cnt == BIT_ACK;
	assign buf_free = !status_register[ST_BF] && !receive_overflow_flag;
	assign addr_match7 = shift_register[7:1] == own_address_register[7:1];
	assign hdr_match = shift_register[7:3] == TEN_BIT_PREFIX &&
		shift_register[2:1] == own_address_register[2:1];
	assign low_match = shift_register == own_address_register;
	assign is_addr_byte = state == I2CSP_ADDR || state == I2CSP_WAIT_ADDR2;

	// frame tracking
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			in_frame <= 1'b0;
		end else if (!slave_mode) begin
			in_frame <= 1'b0;
		end else if (start_det) begin
			in_frame <= 1'b1;
		end else if (stop_det) begin
			in_frame <= 1'b0;
		end
	end

	// bit counter: counts scl rises, wraps after the ack clock
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			bit_cnt <= 4'h0;
		end else if (!slave_mode || start_det || stop_det) begin
			bit_cnt <= 4'h0;
		end else if (scl_rise && state != I2CSP_IDLE) begin
			bit_cnt <= bit_cnt + 4'h1;
		end else if (ninth_fall) begin
			bit_cnt <= 4'h0;
		end
	end

	// shift register: samples on rise, shifts out on fall, loads on write
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			shift_register <= 8'h00;
		end else if (data_buffer_wr && !in_frame_rx_block()) begin
			shift_register <= data_buffer_wdata;
		end else if (scl_rise && bit_cnt < BIT_LAST_DATA && state != I2CSP_IDLE &&
				state != I2CSP_TX) begin
			shift_register <= {shift_register[6:0], sda_s};
		end else if (scl_fall && state == I2CSP_TX && bit_cnt != 4'h0 &&
				bit_cnt < BIT_LAST_DATA) begin
			shift_register <= {shift_register[6:0], 1'b0};
		end
	end

	// buffer writes refused during master activity (no queueing)
	function automatic logic in_frame_rx_block();
		in_frame_rx_block = master_mode && busy;
	endfunction

	// byte-phase state machine
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= I2CSP_IDLE;
			ten_hi_seen <= 1'b0;
			accept <= 1'b0;
		end else if (!slave_mode || stop_det) begin
			state <= I2CSP_IDLE;
			ten_hi_seen <= 1'b0;
			accept <= 1'b0;
		end else if (start_det) begin
			state <= I2CSP_ADDR; // repeated start too
			accept <= 1'b0;
		end else if (byte_end) begin
			case (state)
				I2CSP_ADDR: begin
					if (!ten_mode) begin
						accept <= addr_match7 && buf_free;
					end else if (hdr_match && !shift_register[0]) begin
						accept <= buf_free;
					end else if (hdr_match && shift_register[0] && ten_hi_seen) begin
						accept <= buf_free;
					end else begin
						accept <= 1'b0;
					end
				end
				I2CSP_WAIT_ADDR2: accept <= low_match && buf_free;
				I2CSP_RX: accept <= buf_free;
				default: accept <= 1'b0;
			endcase
		end else if (scl_rise && bit_cnt == BIT_LAST_DATA && state == I2CSP_TX) begin
			// master ack on ninth rise; nack ends the transfer
			if (sda_s) begin
				state <= I2CSP_IDLE;
			end
		end else if (ninth_fall) begin
			case (state)
				I2CSP_ADDR: begin
					if (!accept) begin
						state <= I2CSP_IDLE;
					end else if (shift_register[0]) begin
						state <= I2CSP_TX;
					end else if (ten_mode) begin
						state <= I2CSP_WAIT_ADDR2;
						ten_hi_seen <= 1'b1;
					end else begin
						state <= I2CSP_RX;
					end
				end
				I2CSP_WAIT_ADDR2: state <= accept ? I2CSP_RX : I2CSP_IDLE;
				I2CSP_RX: state <= I2CSP_RX;
				I2CSP_TX: state <= I2CSP_TX;
				default: state <= I2CSP_IDLE;
			endcase
		end
	end

	// ack and transmit drive on sda
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ack_drive <= 1'b0;
			tx_bit_low <= 1'b0;
		end else if (!slave_mode || start_det || stop_det) begin
			ack_drive <= 1'b0;
			tx_bit_low <= 1'b0;
		end else if (byte_end) begin
			ack_drive <= (state != I2CSP_TX) && next_accept();
			tx_bit_low <= 1'b0;
		end else if (ninth_fall) begin
			ack_drive <= 1'b0;
			tx_bit_low <= (state == I2CSP_TX || (state == I2CSP_ADDR && accept &&
				shift_register[0])) ? !shift_register[7] : 1'b0;
		end else if (scl_fall && state == I2CSP_TX && bit_cnt < BIT_LAST_DATA) begin
			tx_bit_low <= !shift_register[6];
		end else if (data_buffer_wr && state == I2CSP_TX && bit_cnt == 4'h0) begin
			// new byte's msb must stand before the first rise
			tx_bit_low <= !data_buffer_wdata[7];
		end else if (state != I2CSP_TX) begin
			tx_bit_low <= 1'b0;
		end
	end

	// accept decision on the eighth fall; any ten-bit header match passes, rw ignored
	function automatic logic next_accept();
		case (state)
			I2CSP_ADDR: next_accept = buf_free && (ten_mode ? hdr_match : addr_match7);
			I2CSP_WAIT_ADDR2: next_accept = buf_free && low_match;
			I2CSP_RX: next_accept = buf_free;
			default: next_accept = 1'b0;
		endcase
	endfunction

	// data buffer, status and overflow
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			data_buffer <= 8'h00;
			status_register <= STATUS_RESET;
			receive_overflow_flag <= 1'b0;
		end else if (!enabled) begin
			status_register <= STATUS_RESET;
			receive_overflow_flag <= 1'b0;
		end else begin
			if (overflow_clr) begin
				receive_overflow_flag <= 1'b0;
			end
			if (data_buffer_rd) begin
				status_register[ST_BF] <= 1'b0;
			end
			if (own_address_wr) begin
				status_register[ST_UA] <= 1'b0;
			end
			if (data_buffer_wr && !in_frame_rx_block()) begin
				data_buffer <= data_buffer_wdata;
				status_register[ST_BF] <= state == I2CSP_TX || slave_mode;
			end
			if (start_det && slave_mode) begin
				status_register[ST_START] <= 1'b1;
				status_register[ST_STOP] <= 1'b0;
			end
			if (stop_det && slave_mode) begin
				status_register[ST_STOP] <= 1'b1;
				status_register[ST_START] <= 1'b0;
			end
			if (byte_end && slave_mode && state != I2CSP_TX && state != I2CSP_IDLE) begin
				if (next_accept()) begin
					data_buffer <= shift_register;
					status_register[ST_BF] <= 1'b1; // set wins over read clear
					status_register[ST_DA] <= state == I2CSP_RX;
					if (state == I2CSP_ADDR) begin
						status_register[ST_RW] <= shift_register[0];
					end
					// low byte always needs a rewrite, a read header never
					if (ten_mode && is_addr_byte &&
							(state == I2CSP_WAIT_ADDR2 || !shift_register[0])) begin
						status_register[ST_UA] <= 1'b1;
					end
				end else if (state == I2CSP_RX || status_register[ST_BF]) begin
					receive_overflow_flag <= 1'b1; // byte lost
				end
			end
			if (scl_rise && bit_cnt == BIT_LAST_DATA && state == I2CSP_TX && sda_s) begin
				status_register <= STATUS_RESET; // nack resets slave status
			end
		end
	end

	// interrupt flag: set wins over firmware clear
	// idle at a ninth fall only follows a nacked transmit byte
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			port_interrupt_flag <= 1'b0;
		end else if (slave_mode && ((ninth_fall && (accept || state == I2CSP_IDLE ||
				state == I2CSP_RX || state == I2CSP_TX)) ||
				(sp_irq && (start_det || stop_det)))) begin
			port_interrupt_flag <= 1'b1;
		end else if (interrupt_clr) begin
			port_interrupt_flag <= 1'b0;
		end
	end

	// clock release bit: hardware clears it to stretch, firmware sets it
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			clock_release_bit <= 1'b1;
		end else if (slave_mode && ninth_fall && accept && state == I2CSP_ADDR &&
				shift_register[0]) begin
			clock_release_bit <= 1'b0; // read match always stretches
		end else if (slave_mode && ninth_fall && state == I2CSP_TX &&
				!status_register[ST_BF]) begin
			clock_release_bit <= 1'b0;
		end else if (slave_mode && ninth_fall && state == I2CSP_RX &&
				stretch_or_start_enable && status_register[ST_BF]) begin
			clock_release_bit <= 1'b0;
		end else if (clock_release_set) begin
			clock_release_bit <= 1'b1;
		end else if (clock_release_clr) begin
			clock_release_bit <= 1'b0;
		end
	end

	// stretch and master control bits; ctrl set refused while busy, stretch set refused only while master busy
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			stretch_or_start_enable <= 1'b0;
			master_ctrl <= 4'h0;
			start_cnt <= 8'h00;
		end else begin
			if (stretch_or_start_enable_set && !(master_mode && busy)) begin
				stretch_or_start_enable <= 1'b1;
				if (master_mode) begin
					start_cnt <= START_HOLD_COUNT;
				end
			end else if (stretch_or_start_enable_clr) begin
				stretch_or_start_enable <= 1'b0;
			end else if (master_mode && stretch_or_start_enable && start_cnt == 8'h01) begin
				stretch_or_start_enable <= 1'b0; // self-clear when done
			end
			if (start_cnt != 8'h00) begin
				start_cnt <= start_cnt - 8'h01;
			end
			if (master_ctrl_set != 4'h0 && !busy) begin
				master_ctrl <= master_ctrl_set;
			end else if (!master_mode) begin
				master_ctrl <= 4'h0;
			end
		end
	end

	// own address register; writing it also releases the ten-bit hold
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			own_address_register <= 8'h00;
		end else if (own_address_wr) begin
			own_address_register <= own_address_wdata;
		end
	end

	// open-drain pins: only driven low, only with direction set to input
	always_comb begin
		scl_out = 1'b0;
		sda_out = 1'b0;
		scl_oe_n = 1'b1;
		sda_oe_n = 1'b1;
		if (enabled && pin_direction_control == 2'b11) begin
			// address hold waits for the ninth fall so the ack clock can finish
			if (slave_mode && !scl_s && (!clock_release_bit ||
					(status_register[ST_UA] && bit_cnt == 4'h0))) begin
				scl_oe_n = 1'b0; // hold clock low
			end
			if (slave_mode && (ack_drive || tx_bit_low)) begin
				sda_oe_n = 1'b0;
			end
			if (master_mode && start_cnt != 8'h00) begin
				sda_oe_n = 1'b0; // start: sda low while scl high
			end
		end
	end
endmodule

// ### include/i2csp_pkg.sv
/*
 * constants for the i2c slave port core: mode codes, address pattern,
 * bit counts and status-vector layout.
 * assumes a single 50 MHz system clock domain.
 */
package i2csp_pkg;
	// mode field encodings
	localparam logic [3:0] MODE_MASTER = 4'h8;
	localparam logic [3:0] MODE_FW_MASTER = 4'hb;
	localparam logic [3:0] MODE_SLV7 = 4'h6;
	localparam logic [3:0] MODE_SLV10 = 4'h7;
	localparam logic [3:0] MODE_SLV7_SP = 4'he;
	localparam logic [3:0] MODE_SLV10_SP = 4'hf;
	// ten-bit address header prefix
	localparam logic [4:0] TEN_BIT_PREFIX = 5'h1e;
	// bit counter values (count of rising edges in a byte)
	localparam logic [3:0] BIT_LAST_DATA = 4'h8;
	localparam logic [3:0] BIT_ACK = 4'h9;
	// status vector bit positions
	localparam int ST_BF = 0;
	localparam int ST_UA = 1;
	localparam int ST_RW = 2;
	localparam int ST_START = 3;
	localparam int ST_STOP = 4;
	localparam int ST_DA = 5;
	localparam logic [5:0] STATUS_RESET = 6'h00;
	// start condition generator hold, in system cycles
	localparam int START_HOLD_NS = 5000;
	localparam int SYS_PERIOD_NS = 20;
	localparam int START_HOLD_CYC = (START_HOLD_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
	localparam logic [7:0] START_HOLD_COUNT = START_HOLD_CYC[7:0];
	// slave byte-phase states
	typedef enum logic [2:0] {
		I2CSP_IDLE = 3'b000,
		I2CSP_ADDR = 3'b001,
		I2CSP_RX = 3'b010,
		I2CSP_TX = 3'b011,
		I2CSP_WAIT_ADDR2 = 3'b100
	} i2csp_state_type;
endpackage

// ### rtl/i2csp_sync.sv
/*
 * two flip-flop synchroniser with edge outputs for the scl/sda pins.
 * assumes the pins are asynchronous to sys_clk.
 */
`timescale 1ns/10ps
module i2csp_sync (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic pin_in,
	output logic level,
	output logic rise,
	output logic fall
);
	logic meta; // first stage, read only by the second
	logic stage2; // stable copy
	logic stage3; // previous stable copy for edges

	// synchroniser chain, resets to the idle-high bus level
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			meta <= 1'b1;
			stage2 <= 1'b1;
			stage3 <= 1'b1;
		end else begin
			meta <= pin_in;
			stage2 <= meta;
			stage3 <= stage2;
		end
	end

	assign level = stage2;
	assign rise = stage2 & ~stage3; // one-cycle pulse
	assign fall = ~stage2 & stage3; // one-cycle pulse
endmodule

// ### tb/i2csp_core_checker.sv
/*
 * concurrent checks on the i2c slave port core's own ports.
 * assumes the single sys_clk domain and the active-low async rst_n.
 */
`timescale 1ns/10ps
module i2csp_core_checker (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic port_enable_bit,
	input wire logic [3:0] mode_select_field,
	input wire logic [1:0] pin_direction_control,
	input wire logic data_buffer_rd,
	input wire logic own_address_wr,
	input wire logic overflow_clr,
	input wire logic interrupt_clr,
	input wire logic clock_release_set,
	input wire logic scl_oe_n,
	input wire logic sda_oe_n,
	input wire logic [5:0] status_register,
	input wire logic receive_overflow_flag,
	input wire logic port_interrupt_flag,
	input wire logic clock_release_bit,
	input wire logic stretch_or_start_enable
);
	import i2csp_pkg::*;
	// start generator hold is about 250 cycles; margin on top
	localparam int START_MAX = 300;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	// every slave code has mode bits 2:1 set
	wire slave_mode = (mode_select_field[2:1] == 2'b11);
	// clock free to run: release set, no address rewrite pending
	sequence released_seq;
		clock_release_bit && !status_register[ST_UA] && slave_mode;
	endsequence
	// release strobe with no rewrite pending one cycle later
	sequence release_req;
		clock_release_set ##1 !status_register[ST_UA];
	endsequence
	a_disabled_quiet: assert property (!port_enable_bit |-> scl_oe_n && sda_oe_n)
		else $error("pins driven while disabled");
	a_dir_gated: assert property (pin_direction_control != 2'h3 |-> scl_oe_n && sda_oe_n)
		else $error("pins driven without input direction");
	a_release_frees: assert property (released_seq ##1 released_seq |-> scl_oe_n)
		else $error("clock held while released");
	a_release_takes: assert property (release_req |-> clock_release_bit)
		else $error("release strobe not taken");
	a_rewrite_clears: assert property (own_address_wr |=> !status_register[ST_UA])
		else $error("address write left update flag");
	a_read_clears: assert property (data_buffer_rd |=> !status_register[ST_BF])
		else $error("buffer read left full flag");
	a_ovf_sticky: assert property (receive_overflow_flag && !overflow_clr && port_enable_bit
		|=> receive_overflow_flag)
		else $error("overflow dropped without clear");
	a_ovf_no_ack: assert property (receive_overflow_flag |-> sda_oe_n)
		else $error("data pulled low during overflow");
	a_irq_sticky: assert property (port_interrupt_flag && !interrupt_clr && port_enable_bit
		|=> port_interrupt_flag)
		else $error("interrupt flag dropped without clear");
	a_start_clears: assert property ((mode_select_field == MODE_MASTER)
		&& $rose(stretch_or_start_enable) |-> ##[1:START_MAX] !stretch_or_start_enable)
		else $error("start bit not self-cleared");
endmodule
bind i2csp_core i2csp_core_checker i2csp_core_checker_inst (
	.sys_clk(sys_clk), .rst_n(rst_n), .port_enable_bit(port_enable_bit),
	.mode_select_field(mode_select_field), .pin_direction_control(pin_direction_control),
	.data_buffer_rd(data_buffer_rd), .own_address_wr(own_address_wr),
	.overflow_clr(overflow_clr), .interrupt_clr(interrupt_clr),
	.clock_release_set(clock_release_set), .scl_oe_n(scl_oe_n), .sda_oe_n(sda_oe_n),
	.status_register(status_register), .receive_overflow_flag(receive_overflow_flag),
	.port_interrupt_flag(port_interrupt_flag), .clock_release_bit(clock_release_bit),
	.stretch_or_start_enable(stretch_or_start_enable)
);

// ### tb/i2csp_bfm.sv
/*
 * behavioural i2c bus master for the slave port core.
 * assumes pull-ups: a line is low only while some party pulls it.
 */
`timescale 1ns/10ps
module i2csp_bfm (
	input wire logic scl_w,
	input wire logic sda_w,
	output logic scl_rel,
	output logic sda_rel
);
	// both lines released, clock stands still between frames
	initial begin
		scl_rel = 1;
		sda_rel = 1;
	end
	// one 160 ns bit: data moves only while clock low
	task automatic bit_io(input logic b, output logic s);
		sda_rel = b;
		#50 scl_rel = 1;
		wait (scl_w === 1'b1); // honours a stretching slave
		#30 s = sda_w;
		#30 scl_rel = 0;
		#50;
	endtask
	// data falls while clock high
	task automatic start();
		sda_rel = 1;
		#50 scl_rel = 1;
		wait (scl_w === 1'b1);
		#80 sda_rel = 0;
		#80 scl_rel = 0;
		#50;
	endtask
	// data rises while clock high
	task automatic stop();
		sda_rel = 0;
		#50 scl_rel = 1;
		wait (scl_w === 1'b1);
		#80 sda_rel = 1;
		#80;
	endtask
	// msb first byte then ninth bit; ack_in is ours when reading
	task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q,
		output logic ack_out);
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], q[i]);
		end
		bit_io(ack_in, ack_out);
	endtask
endmodule

// ### tb/i2c_slave_port_core_bench.sv
/*
 * directed bench for the i2c slave port core: firmware strobes plus a bus master.
 * assumes pull-ups on both lines and the core's one-cycle strobe contract.
 */
`timescale 1ns/10ps
module i2c_slave_port_core_bench;
	import i2csp_pkg::*;
	// firmware side, idle at time zero
	logic sys_clk = 0, rst_n = 0, port_enable_bit = 0, own_address_wr = 0;
	logic [3:0] mode_select_field = MODE_SLV7, master_ctrl_set = 4'h0;
	logic [1:0] pin_direction_control = 2'h3;
	logic [7:0] own_address_wdata = 8'h00, data_buffer_wdata = 8'h00, q;
	logic data_buffer_wr = 0, data_buffer_rd = 0, clock_release_set = 0, overflow_clr = 0;
	logic interrupt_clr = 0, sse_set = 0, sse_clr = 0, ack_seen;
	logic scl_oe_n, sda_oe_n, receive_overflow_flag, port_interrupt_flag, clock_release_bit;
	logic stretch_or_start_enable, scl_rel, sda_rel;
	logic [7:0] data_buffer, own_address_register;
	logic [5:0] status_register;
	logic [3:0] master_ctrl;
	int n_fail = 0, tests_run = 0, cyc = 0;
	// wired-and bus with pull-ups
	wire scl_w = scl_rel & scl_oe_n;
	wire sda_w = sda_rel & sda_oe_n;
	always #10 sys_clk = ~sys_clk;
	i2csp_core i2csp_core_inst (
		.sys_clk(sys_clk), .rst_n(rst_n), .port_enable_bit(port_enable_bit),
		.mode_select_field(mode_select_field), .pin_direction_control(pin_direction_control),
		.stretch_or_start_enable_set(sse_set), .stretch_or_start_enable_clr(sse_clr),
		.master_ctrl_set(master_ctrl_set), .own_address_wdata(own_address_wdata),
		.own_address_wr(own_address_wr), .data_buffer_wdata(data_buffer_wdata),
		.data_buffer_wr(data_buffer_wr), .data_buffer_rd(data_buffer_rd),
		.clock_release_set(clock_release_set), .clock_release_clr(1'b0),
		.overflow_clr(overflow_clr), .interrupt_clr(interrupt_clr), .scl_in(scl_w),
		.sda_in(sda_w), .scl_oe_n(scl_oe_n), .sda_oe_n(sda_oe_n), .scl_out(), .sda_out(),
		.data_buffer(data_buffer), .own_address_register(own_address_register),
		.status_register(status_register), .receive_overflow_flag(receive_overflow_flag),
		.port_interrupt_flag(port_interrupt_flag), .clock_release_bit(clock_release_bit),
		.stretch_or_start_enable(stretch_or_start_enable), .master_ctrl(master_ctrl));
	i2csp_bfm i2csp_bfm_inst (.scl_w(scl_w), .sda_w(sda_w), .scl_rel(scl_rel), .sda_rel(sda_rel));
	// verdict and end of run
	task automatic results();
		$display("checks %0d, mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// compare seen against expected, four-state
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	// strobe k: 0 rd, 1 buf wr, 2 addr wr, 3 release, 4 ovf clr, 5 flag clr,
	// 6 stretch set, 7 ctrl set, 8 stretch clr
	task automatic fw(input int k, input logic [7:0] v);
		@(negedge sys_clk);
		data_buffer_wdata = v;
		own_address_wdata = v;
		case (k)
			0: data_buffer_rd = 1;
			1: data_buffer_wr = 1;
			2: own_address_wr = 1;
			3: clock_release_set = 1;
			4: overflow_clr = 1;
			5: interrupt_clr = 1;
			6: sse_set = 1;
			7: master_ctrl_set = 4'h4;
			default: sse_clr = 1;
		endcase
		@(negedge sys_clk);
		{data_buffer_rd, data_buffer_wr, own_address_wr, clock_release_set} = 4'h0;
		{overflow_clr, interrupt_clr, sse_set, sse_clr} = 4'h0;
		master_ctrl_set = 4'h0;
		@(negedge sys_clk); // let the update land
	endtask
	// one byte on the bus, then let the flags settle
	task automatic xb(input logic [7:0] d, input logic m_ack);
		i2csp_bfm_inst.xfer(d, m_ack, q, ack_seen);
		repeat (6) @(negedge sys_clk);
	endtask
	// hang guard, over twenty times the expected run
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			n_fail++;
			results();
		end
	end
	initial begin
		repeat (20) @(negedge sys_clk);
		rst_n = 1;
		chk(clock_release_bit, 1);
		chk(status_register, STATUS_RESET);
		port_enable_bit = 1;
		fw(2, 8'ha4);
		$display("test reset done");
		// write: auto ack, load, then overflow refusal
		i2csp_bfm_inst.start();
		xb(8'ha4, 1);
		chk(ack_seen, 0);
		chk(data_buffer, 8'ha4);
		chk(status_register[ST_BF], 1);
		chk(status_register[ST_RW], 0);
		chk(port_interrupt_flag, 1);
		fw(0, 0);
		chk(status_register[ST_BF], 0);
		fw(5, 0);
		xb(8'h3c, 1);
		chk(ack_seen, 0);
		chk(data_buffer, 8'h3c);
		chk(scl_oe_n, 1);
		fw(5, 0);
		xb(8'h5a, 1);
		chk(ack_seen, 1);
		chk(data_buffer, 8'h3c);
		chk(port_interrupt_flag, 1);
		chk(receive_overflow_flag, 1);
		i2csp_bfm_inst.stop();
		fw(0, 0);
		chk(receive_overflow_flag, 1);
		fw(4, 0);
		chk(receive_overflow_flag, 0);
		fw(5, 0);
		$display("test write done");
		// foreign address, then port disabled
		i2csp_bfm_inst.start();
		xb(8'h10, 1);
		chk(ack_seen, 1);
		chk(port_interrupt_flag, 0);
		i2csp_bfm_inst.stop();
		@(negedge sys_clk) port_enable_bit = 0;
		i2csp_bfm_inst.start();
		xb(8'ha4, 1);
		chk(ack_seen, 1);
		i2csp_bfm_inst.stop();
		@(negedge sys_clk) port_enable_bit = 1;
		$display("test refuse done");
		// stretch after a received data byte
		fw(6, 0);
		i2csp_bfm_inst.start();
		xb(8'ha4, 1);
		fw(0, 0);
		fw(3, 0);
		xb(8'h81, 1);
		chk(scl_oe_n, 0);
		chk(clock_release_bit, 0);
		chk(data_buffer, 8'h81);
		@(negedge sys_clk) pin_direction_control = 2'h1;
		@(negedge sys_clk) chk(scl_oe_n, 1);
		pin_direction_control = 2'h3;
		fw(0, 0);
		fw(3, 0);
		chk(scl_oe_n, 1);
		i2csp_bfm_inst.stop();
		fw(8, 0);
		fw(5, 0);
		$display("test stretch done");
		// read: hold, load, shift out, master nack
		i2csp_bfm_inst.start();
		xb(8'ha5, 1);
		chk(ack_seen, 0);
		chk(status_register[ST_RW], 1);
		chk(scl_oe_n, 0);
		chk(data_buffer, 8'ha5);
		fw(0, 0);
		fw(1, 8'h43);
		fw(3, 0);
		fw(5, 0);
		xb(8'hff, 1);
		chk(q, 8'h43);
		chk(port_interrupt_flag, 1);
		chk(status_register, STATUS_RESET);
		i2csp_bfm_inst.stop();
		fw(5, 0);
		$display("test read done");
		// ten-bit header, rewrite, low byte
		@(negedge sys_clk) mode_select_field = MODE_SLV10;
		fw(2, 8'hf2);
		i2csp_bfm_inst.start();
		xb(8'hf2, 1);
		chk(ack_seen, 0);
		chk(status_register[ST_UA], 1);
		chk(scl_oe_n, 0);
		fw(0, 0);
		fw(5, 0);
		fw(2, 8'h35);
		chk(status_register[ST_UA], 0);
		chk(scl_oe_n, 1);
		xb(8'h35, 1);
		chk(ack_seen, 0);
		chk(data_buffer, 8'h35);
		chk(status_register[ST_UA], 1);
		fw(0, 0);
		fw(5, 0);
		fw(2, 8'hf2);
		// repeated start, read header: no rewrite, then release and stop
		i2csp_bfm_inst.start();
		xb(8'hf3, 1);
		chk(ack_seen, 0);
		chk(status_register[ST_UA], 0);
		chk(status_register[ST_RW], 1);
		fw(3, 0);
		fw(5, 0);
		i2csp_bfm_inst.stop();
		$display("test tenbit done");
		// start and stop interrupts
		@(negedge sys_clk) mode_select_field = MODE_SLV7_SP;
		fw(2, 8'ha4);
		i2csp_bfm_inst.start();
		repeat (10) @(negedge sys_clk);
		chk(port_interrupt_flag, 1);
		fw(5, 0);
		i2csp_bfm_inst.stop();
		repeat (10) @(negedge sys_clk);
		chk(port_interrupt_flag, 1);
		$display("test events done");
		// master start, busy refusals, self clear
		@(negedge sys_clk) mode_select_field = MODE_MASTER;
		fw(6, 0);
		chk(sda_oe_n, 0);
		fw(7, 0);
		chk(master_ctrl, 4'h0);
		fw(1, 8'h77);
		chk(data_buffer, 8'hf3);
		repeat (START_HOLD_CYC + 10) @(negedge sys_clk);
		chk(stretch_or_start_enable, 0);
		$display("test master done");
		results();
	end
endmodule
